// *** logic/rsc_pkg.sv ***
// Package for the reset source controller: register map, field layout,
// reset-state values and timing counts shared by the design files.
// Assumes a 100 MHz bus clock and a 32-bit AXI4-Lite register port.
package rsc_pkg;

    // Clock rate and derived cycle counts
    localparam int CLK_PERIOD_PS          = 10000;
    localparam int POR_DELAY_CYCLES       = 4064;
    localparam int EXT_LOW_MIN_TCYC_X10   = 15;
    localparam int EXT_LOW_MIN_CYCLES     = (EXT_LOW_MIN_TCYC_X10 + 9) / 10;
    localparam int PULLDOWN_MIN_CYCLES    = 4;
    localparam int WDOG_TIMEOUT_DEFAULT   = 65536;

    // Register byte addresses
    localparam logic [15:0] ADDR_WATCHDOG_SERVICE = 16'h1ff0;
    localparam logic [15:0] ADDR_MISC_CONTROL     = 16'h000c;
    localparam logic [15:0] ADDR_RESET_CAUSE      = 16'h0010;

    // Field positions
    localparam int WATCHDOG_CLEAR_BIT        = 0;
    localparam int LOW_VOLTAGE_ENABLE_BIT    = 0;
    localparam int WATCHDOG_ENABLE_ONCE_BIT  = 1;
    localparam int CAUSE_POR_BIT             = 0;
    localparam int CAUSE_EXT_BIT             = 1;
    localparam int CAUSE_WDOG_BIT            = 2;
    localparam int CAUSE_LV_BIT              = 3;
    localparam int CAUSE_ILLEGAL_BIT         = 4;
    localparam int CAUSE_WIDTH               = 5;

    // Reset values
    localparam logic [7:0]  MISC_CONTROL_RESET = 8'h01;
    localparam logic [4:0]  CAUSE_RESET        = 5'h01;

    // Reset-state values handed to the core and peripherals
    localparam logic [7:0]  CPU_SP_INIT        = 8'hff;
    localparam logic [15:0] CPU_VECTOR_ADDR_HI = 16'h1ffe;
    localparam logic [15:0] CPU_VECTOR_ADDR_LO = 16'h1fff;
    localparam logic [1:0]  CORE_RATE_LONGEST  = 2'h3;
    localparam logic [15:0] TIMER_COUNT_INIT   = 16'hfffc;
    localparam int          SMB_XFER_DONE_BIT  = 7;
    localparam int          SMB_NO_ACK_BIT     = 0;
    localparam logic [7:0]  SMB_STATUS_INIT    = 8'h81;

    // Legal opcode-fetch windows
    localparam logic [15:0] PROG_LO = 16'h0600;
    localparam logic [15:0] PROG_HI = 16'h1dff;
    localparam logic [15:0] VECT_LO = 16'h1ff0;
    localparam logic [15:0] VECT_HI = 16'h1fff;
    localparam logic [15:0] RAM_LO  = 16'h0030;
    localparam logic [15:0] RAM_HI  = 16'h010f;

    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Fetch address legality
    function automatic logic fetch_legal(input logic [15:0] a);
        fetch_legal = ((a >= PROG_LO) && (a <= PROG_HI)) ||
                      ((a >= VECT_LO) && (a <= VECT_HI)) ||
                      ((a >= RAM_LO) && (a <= RAM_HI));
    endfunction

endpackage

// *** logic/rsc_reset_source_controller.sv ***
// Reset source controller: combines power-on, pin, watchdog, low-voltage
// and illegal-fetch resets into one internal reset, drives the reset pin
// pulldown and exposes its registers on AXI4-Lite.
// Assumes aresetn marks power-up with the oscillator running, and that
// the reset pin wire is resolved outside from out and oe_n.
//
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/1ps
module rsc_reset_source_controller #(
    parameter int WDOG_TIMEOUT_CYCLES = rsc_pkg::WDOG_TIMEOUT_DEFAULT
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite slave
    input  wire logic [15:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [15:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Reset pin, open drain
    input  wire logic        reset_pin_in_n,
    output logic             reset_pin_out,
    output logic             reset_pin_oe_n,
    // Reset sources
    input  wire logic        low_voltage_detect,
    input  wire logic        fetch_valid,
    input  wire logic [15:0] fetch_addr,
    // Internal reset and reset-state values
    output logic             core_reset_n,
    output logic [7:0]       cpu_sp_init,
    output logic [15:0]      cpu_vector_addr_hi,
    output logic [15:0]      cpu_vector_addr_lo,
    output logic [1:0]       core_rate_init,
    output logic [15:0]      timer_count_init,
    output logic [7:0]       smb_status_init
);
    localparam int WW = $clog2(WDOG_TIMEOUT_CYCLES + 1);
    localparam int PW = $clog2(rsc_pkg::POR_DELAY_CYCLES + 1);
    localparam int EW = $clog2(rsc_pkg::EXT_LOW_MIN_CYCLES + 1);

    typedef struct packed {
        // Reset combining
        logic [PW-1:0]                    por_cnt;
        logic                             por_done;
        logic [EW-1:0]                    ext_cnt;
        logic                             ext_active;
        logic                             core_rst_n;
        // Watchdog and control
        logic [WW-1:0]                    wdog_cnt;
        logic                             wdog_en;
        logic                             wdog_fire;
        logic                             lv_en;
        logic                             illegal_hit;
        logic [rsc_pkg::CAUSE_WIDTH-1:0]  cause;
        // AXI write side
        logic                             aw_got;
        logic [15:0]                      aw_addr;
        logic                             w_got;
        logic [31:0]                      w_data;
        logic [3:0]                       w_strb;
        logic                             bvalid;
        logic [1:0]                       bresp;
        // AXI read side
        logic                             rvalid;
        logic [31:0]                      rdata;
        logic [1:0]                       rresp;
        // Reset-state values
        logic [7:0]                       sp_init;
        logic [15:0]                      vec_hi;
        logic [15:0]                      vec_lo;
        logic [1:0]                       rate_init;
        logic [15:0]                      tmr_init;
        logic [7:0]                       smb_init;
    } rsc_state_t;

    rsc_state_t s_reg;
    rsc_state_t s_next;

    logic pin_sync_n;
    logic lv_src;
    logic pull_src;
    logic pull_drive;
    logic rst_any;
    logic aw_hs;
    logic w_hs;
    logic ar_hs;
    logic wr_fire;
    logic [rsc_pkg::CAUSE_WIDTH-1:0] cause_set;

    // Pin level is metastable-safe before anything looks at it
    rsc_sync2 #(
        .RESET_LEVEL (1'b1)
    ) u_pin_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .d       (reset_pin_in_n),
        .q       (pin_sync_n)
    );

    // Only the three internal sources may pull the pin
    assign lv_src   = low_voltage_detect && s_reg.lv_en;
    assign pull_src = s_reg.wdog_fire || lv_src || s_reg.illegal_hit;

    rsc_stretch #(
        .MIN_CYCLES (rsc_pkg::PULLDOWN_MIN_CYCLES)
    ) u_pulldown (
        .aclk    (aclk),
        .aresetn (aresetn),
        .src     (pull_src),
        .drive   (pull_drive)
    );

    // Any active source holds the core in reset
    assign rst_any = !s_reg.por_done || s_reg.ext_active || pull_src || pull_drive;

    // Handshakes; one write and one read at a time
    assign aw_hs   = s_axi_awvalid && s_axi_awready;
    assign w_hs    = s_axi_wvalid && s_axi_wready;
    assign ar_hs   = s_axi_arvalid && s_axi_arready;
    assign wr_fire = s_reg.aw_got && s_reg.w_got && !s_reg.bvalid;

    // Events seen this cycle, recorded in the cause register
    always_comb begin
        cause_set = '0;
        cause_set[rsc_pkg::CAUSE_EXT_BIT]     = s_reg.ext_active;
        cause_set[rsc_pkg::CAUSE_WDOG_BIT]    = s_reg.wdog_fire;
        cause_set[rsc_pkg::CAUSE_LV_BIT]      = lv_src;
        cause_set[rsc_pkg::CAUSE_ILLEGAL_BIT] = s_reg.illegal_hit;
    end

    // Next-state logic
    always_comb begin
        s_next = s_reg;

        // Power-up stabilisation count
        if (!s_reg.por_done) begin
            if (s_reg.por_cnt == PW'(rsc_pkg::POR_DELAY_CYCLES - 1)) begin
                s_next.por_done = 1'b1;
            end else begin
                s_next.por_cnt = s_reg.por_cnt + 1'b1;
            end
        end

        // Pin must stay low a minimum time, then holds reset while low
        if (pin_sync_n) begin
            s_next.ext_cnt    = '0;
            s_next.ext_active = 1'b0;
        end else if (s_reg.ext_cnt != EW'(rsc_pkg::EXT_LOW_MIN_CYCLES - 1)) begin
            s_next.ext_cnt = s_reg.ext_cnt + 1'b1;
        end else begin
            s_next.ext_active = 1'b1;
        end

        // Illegal fetch flagged for one cycle
        s_next.illegal_hit = fetch_valid && s_reg.core_rst_n &&
                             !rsc_pkg::fetch_legal(fetch_addr);

        // Watchdog counting and timeout
        s_next.wdog_fire = 1'b0;
        if (s_reg.wdog_en) begin
            if (s_reg.wdog_cnt == WW'(WDOG_TIMEOUT_CYCLES - 1)) begin
                s_next.wdog_cnt  = '0;
                s_next.wdog_fire = 1'b1;
            end else begin
                s_next.wdog_cnt = s_reg.wdog_cnt + 1'b1;
            end
        end

        // Registered internal reset
        s_next.core_rst_n = !rst_any;

        // AXI write address and data, taken in either order
        if (aw_hs) begin
            s_next.aw_got  = 1'b1;
            s_next.aw_addr = s_axi_awaddr;
        end
        if (w_hs) begin
            s_next.w_got  = 1'b1;
            s_next.w_data = s_axi_wdata;
            s_next.w_strb = s_axi_wstrb;
        end

        // Cause register: new events set, a written one clears, set wins
        if (wr_fire && s_reg.aw_addr == rsc_pkg::ADDR_RESET_CAUSE && s_reg.w_strb[0]) begin
            s_next.cause = s_reg.cause & ~s_reg.w_data[rsc_pkg::CAUSE_WIDTH-1:0];
        end
        s_next.cause = s_next.cause | cause_set;

        // Register write effects
        if (wr_fire) begin
            s_next.aw_got = 1'b0;
            s_next.w_got  = 1'b0;
            s_next.bvalid = 1'b1;
            s_next.bresp  = rsc_pkg::RESP_OKAY;
            case (s_reg.aw_addr)
                rsc_pkg::ADDR_WATCHDOG_SERVICE: begin
                    if (s_reg.w_strb[0] && !s_reg.w_data[rsc_pkg::WATCHDOG_CLEAR_BIT]) begin
                        s_next.wdog_cnt  = '0;
                        s_next.wdog_fire = 1'b0;
                    end
                end
                rsc_pkg::ADDR_MISC_CONTROL: begin
                    if (s_reg.w_strb[0]) begin
                        s_next.lv_en = s_reg.w_data[rsc_pkg::LOW_VOLTAGE_ENABLE_BIT];
                        if (s_reg.w_data[rsc_pkg::WATCHDOG_ENABLE_ONCE_BIT]) begin
                            s_next.wdog_en = 1'b1;
                        end
                    end
                end
                rsc_pkg::ADDR_RESET_CAUSE: begin
                end
                default: begin
                    s_next.bresp = rsc_pkg::RESP_SLVERR;
                end
            endcase
        end
        if (s_reg.bvalid && s_axi_bready) begin
            s_next.bvalid = 1'b0;
        end

        // Register reads; service register is write-only and reads zero
        if (ar_hs) begin
            s_next.rvalid = 1'b1;
            s_next.rdata  = '0;
            s_next.rresp  = rsc_pkg::RESP_OKAY;
            case (s_axi_araddr)
                rsc_pkg::ADDR_WATCHDOG_SERVICE: begin
                    s_next.rdata = '0;
                end
                rsc_pkg::ADDR_MISC_CONTROL: begin
                    s_next.rdata[rsc_pkg::LOW_VOLTAGE_ENABLE_BIT]   = s_reg.lv_en;
                    s_next.rdata[rsc_pkg::WATCHDOG_ENABLE_ONCE_BIT] = s_reg.wdog_en;
                end
                rsc_pkg::ADDR_RESET_CAUSE: begin
                    s_next.rdata[rsc_pkg::CAUSE_WIDTH-1:0] = s_reg.cause;
                end
                default: begin
                    s_next.rresp = rsc_pkg::RESP_SLVERR;
                end
            endcase
        end else if (s_reg.rvalid && s_axi_rready) begin
            s_next.rvalid = 1'b0;
        end

        // Any internal reset returns control to its defaults; cause survives
        if (!s_reg.core_rst_n) begin
            s_next.wdog_cnt  = '0;
            s_next.wdog_en   = 1'b0;
            s_next.wdog_fire = 1'b0;
            s_next.lv_en     = rsc_pkg::MISC_CONTROL_RESET[rsc_pkg::LOW_VOLTAGE_ENABLE_BIT];
        end
    end

    // State register; power-up values are constants only
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_reg            <= '0;
            s_reg.lv_en      <= rsc_pkg::MISC_CONTROL_RESET[rsc_pkg::LOW_VOLTAGE_ENABLE_BIT];
            s_reg.cause      <= rsc_pkg::CAUSE_RESET;
            s_reg.ext_active <= 1'b0;
            s_reg.sp_init    <= rsc_pkg::CPU_SP_INIT;
            s_reg.vec_hi     <= rsc_pkg::CPU_VECTOR_ADDR_HI;
            s_reg.vec_lo     <= rsc_pkg::CPU_VECTOR_ADDR_LO;
            s_reg.rate_init  <= rsc_pkg::CORE_RATE_LONGEST;
            s_reg.tmr_init   <= rsc_pkg::TIMER_COUNT_INIT;
            s_reg.smb_init   <= rsc_pkg::SMB_STATUS_INIT;
        end else begin
            s_reg <= s_next;
        end
    end

    // AXI outputs
    assign s_axi_awready = !s_reg.aw_got && !s_reg.bvalid;
    assign s_axi_wready  = !s_reg.w_got && !s_reg.bvalid;
    assign s_axi_bvalid  = s_reg.bvalid;
    assign s_axi_bresp   = s_reg.bresp;
    assign s_axi_arready = !s_reg.rvalid;
    assign s_axi_rvalid  = s_reg.rvalid;
    assign s_axi_rdata   = s_reg.rdata;
    assign s_axi_rresp   = s_reg.rresp;

    // Open drain: only ever drives low, enable active low
    assign reset_pin_out  = 1'b0;
    assign reset_pin_oe_n = !pull_drive;

    // Core reset; peripherals load the values below while it is low, which
    // also clears directions, stop/wait latches and sets the masks
    assign core_reset_n       = s_reg.core_rst_n;
    assign cpu_sp_init        = s_reg.sp_init;
    assign cpu_vector_addr_hi = s_reg.vec_hi;
    assign cpu_vector_addr_lo = s_reg.vec_lo;
    assign core_rate_init     = s_reg.rate_init;
    assign timer_count_init   = s_reg.tmr_init;
    assign smb_status_init    = s_reg.smb_init;
endmodule

// *** logic/rsc_stretch.sv ***
// Pulldown stretcher: drive lasts while the source is active and at
// least MIN_CYCLES in total after the source first appears.
// Assumes src is synchronous to aclk.
`timescale 1ns/1ps
module rsc_stretch #(
    parameter int MIN_CYCLES = rsc_pkg::PULLDOWN_MIN_CYCLES
) (
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic src,
    output logic      drive
);
    localparam int CW = $clog2(MIN_CYCLES + 1);

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic          src_d;
        logic          drive;
    } rsc_stretch_state_t;

    rsc_stretch_state_t s_reg;
    rsc_stretch_state_t s_next;

    // Count starts on the source's rising edge, so a long source is not
    // stretched further and a short one still gets the minimum
    always_comb begin
        s_next       = s_reg;
        s_next.src_d = src;
        if (src && !s_reg.src_d) begin
            s_next.cnt = CW'(MIN_CYCLES - 1);
        end else if (s_reg.cnt != '0) begin
            s_next.cnt = s_reg.cnt - 1'b1;
        end
        s_next.drive = src || (s_reg.cnt != '0);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign drive = s_reg.drive;
endmodule

// *** logic/rsc_sync2.sv ***
// Two-stage level synchroniser for the reset pin input.
// Assumes the input may change at any time relative to aclk.
`timescale 1ns/1ps
module rsc_sync2 #(
    parameter logic RESET_LEVEL = 1'b1
) (
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic d,
    output logic      q
);
    typedef struct packed {
        logic meta;
        logic stable;
    } rsc_sync_state_t;

    rsc_sync_state_t s_reg;
    rsc_sync_state_t s_next;

    // First stage feeds only the second stage
    always_comb begin
        s_next        = s_reg;
        s_next.meta   = d;
        s_next.stable = s_reg.meta;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_reg <= '{meta: RESET_LEVEL, stable: RESET_LEVEL};
        end else begin
            s_reg <= s_next;
        end
    end

    assign q = s_reg.stable;
endmodule

// *** test/rsc_pin_model.sv ***
// Far-side reset circuit on the open-drain reset pin, with a pull-up.
// Assumes hold_low only changes just after a rising aclk edge.
`timescale 1ns/1ps
module rsc_pin_model (
    input  wire logic dut_out,
    input  wire logic dut_oe_n,
    input  wire logic hold_low,
    output logic      pin_n
);
    // Wired pulldowns; the pull-up wins only when nobody pulls
    assign pin_n = !(hold_low || (!dut_oe_n && !dut_out));
endmodule

// *** test/rsc_reset_source_controller_chk.sv ***
// Concurrent checks on the reset source controller's ports.
// Assumes one clock domain and a synchronous active-low aresetn.
`timescale 1ns/1ps
module rsc_reset_source_controller_chk #(
    parameter int WDOG_TIMEOUT_CYCLES = 16
) (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        reset_pin_in_n,
    input wire logic        reset_pin_oe_n,
    input wire logic        low_voltage_detect,
    input wire logic        fetch_valid,
    input wire logic [15:0] fetch_addr,
    input wire logic        core_reset_n,
    input wire logic [7:0]  cpu_sp_init,
    input wire logic [15:0] cpu_vector_addr_hi,
    input wire logic [15:0] timer_count_init
);
    logic [15:0] up_cnt_reg;
    logic [15:0] up_cnt_next;
    logic        bad_fetch;

    // Cycles since power-up release; saturates so long runs never wrap
    always_comb begin
        up_cnt_next = (up_cnt_reg == 16'hffff) ? up_cnt_reg : up_cnt_reg + 16'h0001;
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            up_cnt_reg <= 16'h0000;
        end else begin
            up_cnt_reg <= up_cnt_next;
        end
    end

    // Fetch outside every legal window while the core runs
    assign bad_fetch = fetch_valid && core_reset_n &&
        !(((fetch_addr >= 16'h0600) && (fetch_addr <= 16'h1dff)) ||
          ((fetch_addr >= 16'h1ff0) && (fetch_addr <= 16'h1fff)) ||
          ((fetch_addr >= 16'h0030) && (fetch_addr <= 16'h010f)));

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Pulldown steps: start, four low cycles, release
    sequence pull_start;
        $fell(reset_pin_oe_n);
    endsequence
    sequence pull_four;
        !reset_pin_oe_n [*4] ##1 reset_pin_oe_n;
    endsequence

    por_hold_a: assert property (up_cnt_reg < 16'd4064 |-> !core_reset_n)
        else $error("core left reset before the power-up delay");
    por_release_a: assert property ((up_cnt_reg == 16'd4072) && reset_pin_in_n &&
        $past(reset_pin_in_n, 4) && !low_voltage_detect |-> core_reset_n)
        else $error("core still in reset after the power-up delay");
    por_no_pull_a: assert property ((up_cnt_reg < 16'd4064) && !low_voltage_detect |-> reset_pin_oe_n)
        else $error("pulldown on during power-up");
    pin_no_pull_a: assert property ($fell(reset_pin_in_n) && reset_pin_oe_n &&
        !low_voltage_detect && !bad_fetch |=> reset_pin_oe_n [*4])
        else $error("pulldown on for a pin reset");
    pull_min_a: assert property (pull_start |-> !reset_pin_oe_n [*4])
        else $error("pulldown shorter than four cycles");
    bad_fetch_a: assert property (bad_fetch |-> ##[1:3] (pull_start ##0 pull_four))
        else $error("illegal fetch without a four cycle pulldown");
    src_reset_a: assert property (!reset_pin_oe_n |-> ##[0:1] !core_reset_n)
        else $error("internal source without core reset");
    pin_reset_a: assert property (!reset_pin_in_n [*6] |-> !core_reset_n)
        else $error("pin held low without core reset");
    reset_state_a: assert property (!core_reset_n |-> (cpu_sp_init == 8'hff) &&
        (cpu_vector_addr_hi == 16'h1ffe) && (timer_count_init == 16'hfffc))
        else $error("wrong reset state value");
endmodule

// *** test/test_reset_source_controller.sv ***
// Self-checking bench for the reset source controller over AXI4-Lite.
// Assumes the pin model resolves the open-drain reset wire.
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin samples_checked++; if ((got) !== (exp)) begin \
    $display("Error %s expected %h seen %h", nm, exp, got); error_cnt++; end end
module test_reset_source_controller;
    logic        aclk = 1'b0;
    logic        aresetn, awvalid, wvalid, bready, arvalid, rready, lvd, fv, hold, hit;
    logic [15:0] awaddr, araddr, fa;
    logic [31:0] wdata, d;
    logic [3:0]  wstrb;
    logic [1:0]  r;
    wire  logic  awready, wready, bvalid, arready, rvalid, pin_n, pout, poe_n, crn;
    wire  logic [1:0]  bresp, rresp, rate;
    wire  logic [31:0] rdata;
    wire  logic [7:0]  sp, smb;
    wire  logic [15:0] vhi, vlo, tci;
    int          error_cnt, samples_checked, k, pd, pd2;
    // Legal flag above each fetch address, boundaries on both sides except above 16'h1fff
    logic [16:0] ftab [11] = '{17'h10600, 17'h11dff, 17'h11ff0, 17'h11fff, 17'h10030,
                               17'h1010f, 17'h005ff, 17'h01e00, 17'h01fef, 17'h0002f, 17'h00110};

    always #5 aclk = ~aclk;

    rsc_reset_source_controller #(.WDOG_TIMEOUT_CYCLES(16)) i_dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .reset_pin_in_n(pin_n), .reset_pin_out(pout), .reset_pin_oe_n(poe_n),
        .low_voltage_detect(lvd), .fetch_valid(fv), .fetch_addr(fa), .core_reset_n(crn),
        .cpu_sp_init(sp), .cpu_vector_addr_hi(vhi), .cpu_vector_addr_lo(vlo),
        .core_rate_init(rate), .timer_count_init(tci), .smb_status_init(smb));

    rsc_pin_model i_pin (.dut_out(pout), .dut_oe_n(poe_n), .hold_low(hold), .pin_n(pin_n));

    // Verdict and end of run, shared with the hang guard
    task automatic final_report;
        $display("Checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // Bus write; channels released one by one as each is taken
    task automatic wr(input logic [15:0] a, input logic [31:0] v);
        int n;
        n = 0;
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && n < 50);
        r = bresp;
        if (n >= 50) error_cnt++;
        bready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic rd(input logic [15:0] a);
        int n;
        n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (arvalid && arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && n < 50);
        d = rdata;
        r = rresp;
        if (n >= 50) error_cnt++;
        rready <= 1'b0;
        @(posedge aclk);
    endtask

    // Counts pulldown cycles and notes any core reset over n cycles
    task automatic watch(input int n, output int p);
        p = 0;
        hit = 1'b0;
        repeat (n) begin
            @(posedge aclk);
            if (poe_n === 1'b0) p++;
            if (crn === 1'b0) hit = 1'b1;
        end
    endtask

    task automatic wait_crn(input int n);
        k = 0;
        while (crn !== 1'b1 && k < n) begin
            @(posedge aclk);
            k++;
        end
        `CHK("core_reset_n", 1'b1, crn)
    endtask

    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, lvd, fv, hold} = '0;
        {awaddr, araddr, fa, wdata} = '0;
        wstrb = 4'hf;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        wait_crn(4200);
        `CHK("por_len", 1'b1, (k >= 4064) && (k <= 4070))
        `CHK("sp", 8'hff, sp)
        `CHK("vec", 32'h1ffe1fff, {vhi, vlo})
        `CHK("rate", 2'h3, rate)
        `CHK("timer", 16'hfffc, tci)
        `CHK("smb", 8'h81, smb)
        rd(16'h0010);
        `CHK("cause", 32'h1, d)
        rd(16'h000c);
        `CHK("misc", 32'h1, d)
        rd(16'h1ff0);
        `CHK("wdog_rd", 32'h0, d)
        rd(16'h0020);
        `CHK("unmapped", 2'h2, r)
        wr(16'h0020, 32'h0);
        `CHK("wr_unmapped", 2'h2, r)
        $display("Test power-up done");
        // Pin reset: core held while low, no pulldown at all
        wr(16'h0010, 32'h1f);
        `CHK("wr_okay", 2'h0, r)
        hold <= 1'b1;
        watch(10, pd);
        `CHK("ext_reset", 1'b1, hit)
        hold <= 1'b0;
        watch(12, pd2);
        `CHK("ext_pull", 0, pd + pd2)
        wait_crn(40);
        rd(16'h0010);
        `CHK("ext_cause", 32'h2, d)
        $display("Test pin reset done");
        // Watchdog: set-once enable, clears keep it quiet, then timeout
        wr(16'h000c, 32'h3);
        wr(16'h000c, 32'h1);
        rd(16'h000c);
        `CHK("wdog_on", 32'h3, d)
        repeat (8) wr(16'h1ff0, 32'h0);
        `CHK("wdog_clr", 1'b1, crn)
        wr(16'h0010, 32'h1f);
        wr(16'h1ff0, 32'h1);
        watch(30, pd);
        `CHK("wdog_fire", 1'b1, hit)
        `CHK("wdog_pull", 1'b1, pd >= 4)
        wait_crn(40);
        rd(16'h000c);
        `CHK("misc_rst", 32'h1, d)
        rd(16'h0010);
        `CHK("wdog_cause", 32'h4, d & 32'h1c)
        watch(40, pd);
        `CHK("wdog_off", 1'b0, hit)
        $display("Test watchdog done");
        // Low voltage: pulldown lasts the source, enable gates it
        wr(16'h0010, 32'h1f);
        lvd <= 1'b1;
        watch(8, pd);
        lvd <= 1'b0;
        watch(12, pd2);
        `CHK("lv_reset", 1'b1, hit)
        `CHK("lv_pull", 8, pd + pd2)
        wait_crn(40);
        rd(16'h0010);
        `CHK("lv_cause", 32'h8, d & 32'h1c)
        wr(16'h000c, 32'h0);
        lvd <= 1'b1;
        watch(10, pd);
        lvd <= 1'b0;
        `CHK("lv_off", 1'b0, hit)
        $display("Test low voltage done");
        // Fetch windows at each boundary
        foreach (ftab[i]) begin
            fa <= ftab[i][15:0];
            fv <= 1'b1;
            @(posedge aclk);
            fv <= 1'b0;
            watch(10, pd);
            `CHK("fetch_reset", ~ftab[i][16], hit)
            `CHK("fetch_pull", ftab[i][16] ? 0 : 4, pd)
            wait_crn(40);
        end
        rd(16'h000c);
        `CHK("lv_back_on", 32'h1, d)
        $display("Test fetch done");
        // Second power-up with the pin still low at the end of the delay
        hold <= 1'b1;
        aresetn <= 1'b0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        watch(4100, pd);
        `CHK("por_pin_low", 1'b0, crn)
        `CHK("por_pull", 0, pd)
        hold <= 1'b0;
        wait_crn(20);
        $display("Test power-up with pin low done");
        final_report;
    end

    // Hang guard well beyond the expected run of about 9000 cycles
    initial begin
        #200000;
        error_cnt++;
        final_report;
    end
endmodule

bind rsc_reset_source_controller rsc_reset_source_controller_chk #(
    .WDOG_TIMEOUT_CYCLES(WDOG_TIMEOUT_CYCLES)) i_chk (
    .aclk(aclk), .aresetn(aresetn), .reset_pin_in_n(reset_pin_in_n), .reset_pin_oe_n(reset_pin_oe_n),
    .low_voltage_detect(low_voltage_detect), .fetch_valid(fetch_valid), .fetch_addr(fetch_addr),
    .core_reset_n(core_reset_n), .cpu_sp_init(cpu_sp_init), .cpu_vector_addr_hi(cpu_vector_addr_hi),
    .timer_count_init(timer_count_init));
